// >>> verilog/asdu_pkg.sv
// shared constants for the arithmetic shift and divide unit
package asdu_pkg;
  localparam int QW = 9;
  localparam int WW = 36;
  localparam int NQ = 4;
  localparam int IW = 14;
  // opcode holding values
  localparam logic [3:0] OP_ASH_P = 4'h0;
  localparam logic [3:0] OP_ASH_S = 4'h1;
  localparam logic [3:0] OP_ASH_J = 4'h2;
  localparam logic [3:0] OP_ROT_P = 4'h3;
  localparam logic [3:0] OP_ROT_S = 4'h4;
  localparam logic [3:0] OP_ROT_J = 4'h5;
  localparam logic [3:0] OP_NRM_P = 4'h6;
  localparam logic [3:0] OP_NRM_J = 4'h7;
  localparam logic [3:0] OP_TALLY = 4'h8;
  localparam logic [3:0] OP_DIV = 4'h9;
  // fracture codes
  localparam logic [1:0] FR_F1 = 2'h0;
  localparam logic [1:0] FR_F2 = 2'h1;
  localparam logic [1:0] FR_F3 = 2'h2;
  localparam logic [1:0] FR_F4 = 2'h3;
  // instruction word fields
  localparam int OP_LSB = 10;
  localparam int FR_LSB = 4;
  localparam int ACT_LSB = 0;
  localparam int START_BIT = 16;
  localparam int REGOP_BIT = 15;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ACC_LO = 8'h04;
  localparam logic [7:0] A_ACC_HI = 8'h08;
  localparam logic [7:0] A_EXT_LO = 8'h0C;
  localparam logic [7:0] A_EXT_HI = 8'h10;
  localparam logic [7:0] A_CNT_LO = 8'h14;
  localparam logic [7:0] A_CNT_HI = 8'h18;
  localparam logic [7:0] A_FLAGS = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  // values and counts
  localparam logic [8:0] QONES = 9'h1FF;
  localparam logic [35:0] WORD_RST = 36'h0;
  localparam logic [7:0] DIV_STEPS = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : asdu_pkg

// >>> verilog/asdu_top.sv
// shift, normalize, tally and divide close-out datapath with axi4-lite
`timescale 1ns/1ps
// Functional notes
// - divide step complements divisor when accumulator and divisor signs match
// - final fix-up add when accumulator sign is zero
// - after divide loop swap accumulator and extension
// - final step: remainder fix, quotient fix, overflow from quotient sign
// - scale multiplies each subword by power of two keeping sign
// - rotate moves every bit including sign within subword
// - shift count of each subword lives in its count sign quarter
// - scale complements count quarter when stored sign flag is zero
// - sign flag zero shifts left, one shifts right
// - scale never shifts into sign; sign fills vacated end
// - pending overflow: complement sign, shift, clear overflow flag
// - rotate is a closed ring, ignores and keeps overflow flags
// - iteration counter steps per shift; count register sets shifts
// - normalize shifts into half..one, count reduced per left shift
// - normalize stops by iteration limit on all zeros or ones
// - normalize treats pending overflow like scale
// - tally loads operand into accumulator, leaves extension alone
// - tally rotates one revolution adding ones into count quarter
// - tally leaves overflow flags unchanged
// - register-operand op loads holding registers straight from bits
// - register-operand op skips operand load, reuses count register
// - control supplies quarter activity levels only for register-operand ops; others use the pins
module asdu_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [35:0] operand_i,
  input wire logic [3:0] sign_extend_quarter_active_i,
  output logic busy_o,
  output logic done_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_LOAD, S_PREP, S_SHIFT, S_DSTEP,
    S_DFIX, S_DSWAP, S_DFINAL, S_DONE
  } asdu_state_t;

  // highest quarter of the subword holding quarter q
  function automatic int hq(input int q, input logic [1:0] f);
    case (f)
      asdu_pkg::FR_F1: return 3;
      asdu_pkg::FR_F2: return (q >= 2) ? 3 : 1;
      asdu_pkg::FR_F3: return (q >= 1) ? 3 : 0;
      default: return q;
    endcase
  endfunction : hq

  // lowest quarter of the subword holding quarter q
  function automatic int lq(input int q, input logic [1:0] f);
    case (f)
      asdu_pkg::FR_F1: return 0;
      asdu_pkg::FR_F2: return (q >= 2) ? 2 : 0;
      asdu_pkg::FR_F3: return (q >= 1) ? 1 : 0;
      default: return q;
    endcase
  endfunction : lq

  // ones-complement add with end-around carry
  function automatic logic [35:0] oc_add(input logic [35:0] a,
                                         input logic [35:0] b);
    logic [36:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[35:0] + {35'h0, s[36]};
  endfunction : oc_add

  // byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) begin
        r[k*8 +: 8] = n[k*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // one shift step of a or a:b per subword, enabled per quarter
  function automatic logic [71:0] shift_ab(input logic [35:0] a,
    input logic [35:0] b, input logic [1:0] f, input logic [3:0] en,
    input logic [3:0] rt, input logic rot, input logic jn);
    logic [35:0] an;
    logic [35:0] bn;
    logic [35:0] al;
    logic [35:0] ar;
    logic [35:0] bl;
    logic [35:0] br;
    int h;
    int l;
    int q;
    an = a;
    bn = b;
    al = {a[34:0], 1'b0};
    ar = {1'b0, a[35:1]};
    bl = {b[34:0], 1'b0};
    br = {1'b0, b[35:1]};
    h = 0;
    l = 0;
    q = 0;
    for (int i = 0; i < 36; i++) begin
      q = i / 9;
      h = hq(q, f) * 9 + 8;
      l = lq(q, f) * 9;
      if (en[q] && !rt[hq(q, f)]) begin
        if (i == l) begin
          an[i] = jn ? b[h] : a[h];
        end else if (i == h && !rot) begin
          an[i] = a[i];
        end else begin
          an[i] = al[i];
        end
        bn[i] = (i == l) ? a[h] : bl[i];
      end else if (en[q]) begin
        if (i == h) begin
          an[i] = !rot ? a[h] : (jn ? b[l] : a[l]);
        end else begin
          an[i] = ar[i];
        end
        bn[i] = (i == h) ? a[l] : br[i];
      end
    end
    return {an, bn};
  endfunction : shift_ab

  asdu_state_t state_reg;
  logic [35:0] acc_reg;
  logic [35:0] ext_reg;
  logic [35:0] cnt_reg;
  logic [3:0] ysign_reg;
  logic [3:0] ovf_reg;
  logic [7:0] iteration_counter_reg;
  logic [3:0] arith_opcode_holding_reg;
  logic [5:0] arith_config_holding_reg;
  logic regop_reg;
  logic done_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic wr_fire;
  logic start_wr;
  logic [1:0] frac;
  logic [3:0] act;
  logic is_scale;
  logic is_rot;
  logic is_norm;
  logic is_tally;
  logic joined;
  logic second;
  logic [3:0] go;
  logic [3:0] rt;
  logic [3:0] en;
  logic [71:0] sh;
  logic [35:0] acc_sh;
  logic [35:0] ext_sh;
  logic [35:0] cnt_sh;
  logic [35:0] dv_d;
  logic [35:0] dv_sum;

  // bus handshake outputs
  assign s_axi_awready_o = !aw_have_reg;
  assign s_axi_wready_o = !w_have_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign busy_o = (state_reg != S_IDLE);
  assign done_o = done_reg;

  // a write is carried out once address and data are both held
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign start_wr = wr_fire && (awaddr_reg == asdu_pkg::A_CTRL) &&
                    wstrb_reg[2] && wdata_reg[asdu_pkg::START_BIT] &&
                    (state_reg == S_IDLE);

  // operation class decode from the opcode holding register
  always_comb begin
    frac = arith_config_holding_reg[5:4];
    act = regop_reg ? arith_config_holding_reg[3:0]
                  : sign_extend_quarter_active_i;
    is_scale = (arith_opcode_holding_reg <= asdu_pkg::OP_ASH_J);
    is_rot = (arith_opcode_holding_reg >= asdu_pkg::OP_ROT_P) &&
             (arith_opcode_holding_reg <= asdu_pkg::OP_ROT_J);
    is_norm = (arith_opcode_holding_reg == asdu_pkg::OP_NRM_P) ||
              (arith_opcode_holding_reg == asdu_pkg::OP_NRM_J);
    is_tally = (arith_opcode_holding_reg == asdu_pkg::OP_TALLY);
    joined = (arith_opcode_holding_reg == asdu_pkg::OP_ASH_J) ||
             (arith_opcode_holding_reg == asdu_pkg::OP_ROT_J) ||
             (arith_opcode_holding_reg == asdu_pkg::OP_NRM_J);
    second = (arith_opcode_holding_reg == asdu_pkg::OP_ASH_S) ||
             (arith_opcode_holding_reg == asdu_pkg::OP_ROT_S);
  end

  // per-subword go decision and the next shifted values
  always_comb begin
    logic [7:0] len;
    len = 8'h0;
    go = 4'h0;
    cnt_sh = cnt_reg;
    for (int s = 0; s < 4; s++) begin
      len = 8'((s - lq(s, frac) + 1) * asdu_pkg::QW);
      if (hq(s, frac) == s && act[s]) begin
        if (is_scale || is_rot) begin
          go[s] = (cnt_reg[s*9 +: 9] != asdu_pkg::QONES);
        end else if (is_norm) begin
          go[s] = (acc_reg[s*9+8] == acc_reg[s*9+7]) &&
                  (iteration_counter_reg <
                   (joined ? 8'(len * 2) : len));
        end else if (is_tally) begin
          go[s] = (iteration_counter_reg < len);
        end
      end
      if (go[s] && (is_scale || is_rot)) begin
        cnt_sh[s*9 +: 9] = cnt_reg[s*9 +: 9] + 9'h001;
      end else if (go[s] && is_norm) begin
        cnt_sh[s*9 +: 9] = cnt_reg[s*9 +: 9] - 9'h001;
      end else if (go[s] && is_tally) begin
        cnt_sh[s*9 +: 9] = cnt_reg[s*9 +: 9] +
                           {8'h0, acc_reg[s*9+8]};
      end
    end
    rt = (is_scale || is_rot) ? ysign_reg : 4'h0;
    for (int q = 0; q < 4; q++) begin
      en[q] = act[q] && go[hq(q, frac)];
    end
    if (second) begin
      sh = shift_ab(ext_reg, acc_reg, frac, en, rt,
                    is_rot || is_tally, 1'b0);
      acc_sh = acc_reg;
      ext_sh = sh[71:36];
    end else begin
      sh = shift_ab(acc_reg, ext_reg, frac, en, rt,
                    is_rot || is_tally, joined);
      acc_sh = sh[71:36];
      ext_sh = joined ? sh[35:0] : ext_reg;
    end
  end

  // divide step terms: divisor flipped when signs match
  always_comb begin
    dv_d = (acc_reg[35] == cnt_reg[35]) ? ~cnt_reg : cnt_reg;
    dv_sum = oc_add(acc_reg, dv_d);
  end

  // bus write channel capture and response
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= asdu_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_have_reg) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_have_reg) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (awaddr_reg <= asdu_pkg::A_STATUS &&
                      awaddr_reg[1:0] == 2'h0) ?
                     asdu_pkg::RESP_OKAY : asdu_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // bus read channel
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= asdu_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= asdu_pkg::RESP_OKAY;
      case (s_axi_araddr_i)
        asdu_pkg::A_CTRL: rdata_reg <= {16'h0, regop_reg, 1'b0,
          arith_opcode_holding_reg, 4'h0, arith_config_holding_reg};
        asdu_pkg::A_ACC_LO: rdata_reg <= acc_reg[31:0];
        asdu_pkg::A_ACC_HI: rdata_reg <= {28'h0, acc_reg[35:32]};
        asdu_pkg::A_EXT_LO: rdata_reg <= ext_reg[31:0];
        asdu_pkg::A_EXT_HI: rdata_reg <= {28'h0, ext_reg[35:32]};
        asdu_pkg::A_CNT_LO: rdata_reg <= cnt_reg[31:0];
        asdu_pkg::A_CNT_HI: rdata_reg <= {28'h0, cnt_reg[35:32]};
        asdu_pkg::A_FLAGS: rdata_reg <= {24'h0, ysign_reg, ovf_reg};
        asdu_pkg::A_STATUS: rdata_reg <= {16'h0,
          iteration_counter_reg, 7'h0, busy_o};
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= asdu_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // sequencer and datapath registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= S_IDLE;
      acc_reg <= asdu_pkg::WORD_RST;
      ext_reg <= asdu_pkg::WORD_RST;
      cnt_reg <= asdu_pkg::WORD_RST;
      ysign_reg <= 4'h0;
      ovf_reg <= 4'h0;
      iteration_counter_reg <= 8'h00;
      arith_opcode_holding_reg <= 4'h0;
      arith_config_holding_reg <= 6'h00;
      regop_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_wr) begin
            arith_opcode_holding_reg <=
              wdata_reg[asdu_pkg::OP_LSB +: 4];
            arith_config_holding_reg <=
              wdata_reg[asdu_pkg::ACT_LSB +: 6];
            regop_reg <= wdata_reg[asdu_pkg::REGOP_BIT];
            iteration_counter_reg <= 8'h00;
            state_reg <= S_LOAD;
          end else if (wr_fire) begin
            case (awaddr_reg)
              asdu_pkg::A_ACC_LO: acc_reg[31:0] <=
                merge(acc_reg[31:0], wdata_reg, wstrb_reg);
              asdu_pkg::A_ACC_HI: if (wstrb_reg[0])
                acc_reg[35:32] <= wdata_reg[3:0];
              asdu_pkg::A_EXT_LO: ext_reg[31:0] <=
                merge(ext_reg[31:0], wdata_reg, wstrb_reg);
              asdu_pkg::A_EXT_HI: if (wstrb_reg[0])
                ext_reg[35:32] <= wdata_reg[3:0];
              asdu_pkg::A_CNT_LO: cnt_reg[31:0] <=
                merge(cnt_reg[31:0], wdata_reg, wstrb_reg);
              asdu_pkg::A_CNT_HI: if (wstrb_reg[0])
                cnt_reg[35:32] <= wdata_reg[3:0];
              asdu_pkg::A_FLAGS: if (wstrb_reg[0])
                ovf_reg <= wdata_reg[3:0];
              default: ;
            endcase
          end
        end
        S_LOAD: begin
          if (!regop_reg && is_tally) begin
            acc_reg <= operand_i;
          end else if (!regop_reg) begin
            cnt_reg <= operand_i;
          end
          state_reg <= S_PREP;
        end
        S_PREP: begin
          if (arith_opcode_holding_reg == asdu_pkg::OP_DIV) begin
            ysign_reg[3] <= cnt_reg[35];
            ovf_reg[3] <= acc_reg[35];
            if (!acc_reg[35]) begin
              acc_reg <= ~acc_reg;
              ext_reg <= ~ext_reg;
            end
            state_reg <= S_DSTEP;
          end else begin
            for (int s = 0; s < 4; s++) begin
              if (hq(s, frac) == s && act[s]) begin
                if (is_scale || is_rot) begin
                  ysign_reg[s] <= cnt_reg[s*9+8];
                  if (!cnt_reg[s*9+8]) begin
                    cnt_reg[s*9 +: 9] <= ~cnt_reg[s*9 +: 9];
                  end
                end
                if ((is_scale || is_norm) && ovf_reg[s]) begin
                  if (second) begin
                    ext_reg[s*9+8] <= ~ext_reg[s*9+8];
                  end else begin
                    acc_reg[s*9+8] <= ~acc_reg[s*9+8];
                  end
                  ovf_reg[s] <= 1'b0;
                end
              end
            end
            state_reg <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (|go) begin
            acc_reg <= acc_sh;
            ext_reg <= ext_sh;
            cnt_reg <= cnt_sh;
            iteration_counter_reg <=
              iteration_counter_reg + 8'h01;
          end else begin
            state_reg <= S_DONE;
          end
        end
        S_DSTEP: begin
          if (iteration_counter_reg == asdu_pkg::DIV_STEPS) begin
            state_reg <= S_DFIX;
          end else begin
            cnt_reg <= dv_d;
            acc_reg <= {dv_sum[34:0], ext_reg[35]};
            ext_reg <= {ext_reg[34:0], ~(dv_sum[35] ^ dv_d[35])};
            iteration_counter_reg <= iteration_counter_reg + 8'h01;
          end
        end
        S_DFIX: begin
          if (!acc_reg[35]) begin
            acc_reg <= oc_add(acc_reg, cnt_reg);
          end
          state_reg <= S_DSWAP;
        end
        S_DSWAP: begin
          acc_reg <= ext_reg;
          ext_reg <= acc_reg;
          state_reg <= S_DFINAL;
        end
        S_DFINAL: begin
          ext_reg <= ovf_reg[3] ? ext_reg : ~ext_reg;
          acc_reg <= (ovf_reg[3] == ysign_reg[3]) ?
                     acc_reg : ~acc_reg;
          ovf_reg[3] <= acc_reg[35];
          state_reg <= S_DONE;
        end
        S_DONE: begin
          done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule : asdu_top

// >>> test/asdu_sva.sv
// checker on the bus handshake and instruction completion ports
`timescale 1ns/1ps
module asdu_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // write answer: legal code, held until taken, channels freed with it
  resp_code_a: assert property (
    s_axi_bvalid_o |-> s_axi_bresp_o inside {2'h0, 2'h2})
    else $error("illegal write response code");
  b_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  b_block_a: assert property (
    $rose(s_axi_bvalid_o) |-> s_axi_awready_o && s_axi_wready_o)
    else $error("write channels not freed with response");
  // read answer: one cycle after address, held until taken
  r_answer_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data not returned next cycle");
  r_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  ar_gate_a: assert property (
    s_axi_arready_o == !s_axi_rvalid_o)
    else $error("read address ready wrong");
  // instruction end: single pulse, exactly when work stops
  done_pulse_a: assert property (
    done_o |=> !done_o)
    else $error("done longer than one cycle");
  done_end_a: assert property (
    $fell(busy_o) |-> done_o && !busy_o)
    else $error("busy ended without done");
  busy_bound_a: assert property (
    $rose(busy_o) |-> ##[1:700] !busy_o)
    else $error("instruction never finished");
  // main scenarios reached
  cover property (done_o);
  cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
  cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule : asdu_sva

bind asdu_top asdu_sva i_asdu_sva (
  .clk_i(clk_i), .reset_i(reset_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .busy_o(busy_o), .done_o(done_o)
);

// >>> test/asdu_xchg_model.sv
// far-side model: operand exchange path and quarter activity levels
`timescale 1ns/1ps
module asdu_xchg_model (
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic [35:0] val_i,
  input wire logic [3:0] act_i,
  output logic [35:0] operand_o,
  output logic [3:0] act_o
);
  logic [35:0] junk_reg = 36'h5_A5A5_A5A5;
  // filler flips every cycle so a stale operand is never seen
  always_ff @(posedge clk_i) begin
    junk_reg <= ~junk_reg;
  end
  // operand offered only while an instruction runs
  assign operand_o = busy_i ? val_i : junk_reg;
  // the same levels that steer sign extension upstream
  assign act_o = act_i;
endmodule : asdu_xchg_model

// >>> test/tb.sv
// self-checking bench: bus master, scenarios and verdict
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdt, d;
  logic [35:0] val = 36'h0, opnd, v;
  logic [3:0] act = 4'hF, acto;
  logic awr, wrd, bv, arr, rv, busy, done;
  logic [1:0] br, rr, rsp;
  int checks = 0, error_cnt = 0;
  asdu_top i_asdu_top (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .operand_i(opnd),
    .sign_extend_quarter_active_i(acto), .busy_o(busy), .done_o(done));
  asdu_xchg_model i_asdu_xchg_model (.clk_i(clk_i), .busy_i(busy),
    .val_i(val), .act_i(act), .operand_o(opnd), .act_o(acto));
  // clock generation
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic hang;
    error_cnt++;
    $display("BAD wait exp answer got none");
    final_report();
  endtask : hang
  task automatic cmp(input string nm, input logic [35:0] e,
      input logic [35:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // write: address and data offered together, released as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dd,
      output logic [1:0] r);
    logic pa, pw, ha, hw;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    @(posedge clk_i);
    awa <= a;
    wd <= dd;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_i);
      ha = awr;
      hw = wrd;
      @(posedge clk_i);
      if (pa && ha === 1'b1) begin
        awv <= 1'b0;
        pa = 1'b0;
      end
      if (pw && hw === 1'b1) begin
        wv <= 1'b0;
        pw = 1'b0;
      end
      if (++n > 99) hang();
    end
    do begin
      @(negedge clk_i);
      if (++n > 199) hang();
    end while (bv !== 1'b1);
    r = br;
    @(posedge clk_i);
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dd,
      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk_i);
      if (++n > 99) hang();
    end while (arr !== 1'b1);
    @(posedge clk_i);
    arv <= 1'b0;
    do begin
      @(negedge clk_i);
      if (++n > 199) hang();
    end while (rv !== 1'b1);
    dd = rdt;
    r = rr;
    @(posedge clk_i);
    rry <= 1'b0;
  endtask : rd
  task automatic w36(input logic [7:0] a, input logic [35:0] x);
    wr(a, x[31:0], rsp);
    wr(a + 8'h04, {28'h0, x[35:32]}, rsp);
  endtask : w36
  task automatic r36(input logic [7:0] a, output logic [35:0] x);
    logic [31:0] lo;
    rd(a, lo, rsp);
    rd(a + 8'h04, d, rsp);
    x = {d[3:0], lo};
  endtask : r36
  task automatic c36(input string nm, input logic [7:0] a,
      input logic [35:0] e);
    r36(a, v);
    cmp(nm, e, v);
  endtask : c36
  task automatic cf(input string nm, input logic [3:0] e);
    rd(asdu_pkg::A_FLAGS, d, rsp);
    cmp(nm, 36'(e), 36'(d[3:0]));
  endtask : cf
  function automatic logic [31:0] cw(input logic [3:0] op,
      input logic [1:0] fr, input logic [3:0] ac, input logic ro);
    cw = 32'h0;
    cw[asdu_pkg::START_BIT] = 1'b1;
    cw[asdu_pkg::REGOP_BIT] = ro;
    cw[asdu_pkg::OP_LSB +: 4] = op;
    cw[asdu_pkg::FR_LSB +: 2] = fr;
    cw[asdu_pkg::ACT_LSB +: 4] = ac;
  endfunction : cw
  // start an instruction and wait for its done pulse
  task automatic go(input logic [31:0] c);
    int n;
    n = 0;
    wr(asdu_pkg::A_CTRL, c, rsp);
    do begin
      @(negedge clk_i);
      if (++n > 999) hang();
    end while (done !== 1'b1);
  endtask : go
  task automatic t_regs;
    c36("acc reset", asdu_pkg::A_ACC_LO, 36'h0);
    rd(8'h24, d, rsp);
    cmp("unmapped rd", 36'h2, 36'(rsp));
    wr(8'h24, 32'h1, rsp);
    cmp("unmapped wr", 36'h2, 36'(rsp));
  endtask : t_regs
  task automatic t_rot;
    logic [31:0] c;
    c = cw(asdu_pkg::OP_ROT_P, asdu_pkg::FR_F1, 4'hF, 1'b1);
    w36(asdu_pkg::A_ACC_LO, 36'h8_0000_0001);
    w36(asdu_pkg::A_CNT_LO, 36'h0_1800_0000);
    wr(asdu_pkg::A_FLAGS, 32'h0000_000F, rsp);
    go(c);
    c36("rot acc", asdu_pkg::A_ACC_LO, 36'h0_0000_000C);
    cf("rot ovf", 4'hF);
    rd(asdu_pkg::A_CTRL, d, rsp);
    cmp("ctrl", 36'(c[13:0]), 36'(d[13:0]));
  endtask : t_rot
  task automatic t_scl;
    logic [31:0] c;
    c = cw(asdu_pkg::OP_ASH_P, asdu_pkg::FR_F1, 4'hF, 1'b1);
    w36(asdu_pkg::A_ACC_LO, 36'h0_0000_0001);
    w36(asdu_pkg::A_CNT_LO, 36'h0_1000_0000);
    wr(asdu_pkg::A_FLAGS, 32'h0000_0008, rsp);
    go(c);
    c36("scl left", asdu_pkg::A_ACC_LO, 36'h8_0000_0007);
    cf("scl ovf", 4'h0);
    w36(asdu_pkg::A_ACC_LO, 36'h8_0000_0010);
    w36(asdu_pkg::A_CNT_LO, 36'hF_E800_0000);
    go(c);
    c36("scl right", asdu_pkg::A_ACC_LO, 36'hE_0000_0004);
    c36("scl cnt", asdu_pkg::A_CNT_LO, 36'hF_F800_0000);
  endtask : t_scl
  task automatic t_nrm;
    logic [31:0] c;
    c = cw(asdu_pkg::OP_NRM_P, asdu_pkg::FR_F1, 4'hF, 1'b0);
    w36(asdu_pkg::A_ACC_LO, 36'h0_1000_0000);
    val <= 36'h0_8000_0000;
    go(c);
    c36("nrm acc", asdu_pkg::A_ACC_LO, 36'h4_0000_0000);
    r36(asdu_pkg::A_CNT_LO, v);
    cmp("nrm cnt", 36'h00A, 36'(v[35:27]));
    w36(asdu_pkg::A_ACC_LO, 36'h0);
    go(c);
    c36("nrm zero", asdu_pkg::A_ACC_LO, 36'h0);
  endtask : t_nrm
  task automatic t_tally;
    w36(asdu_pkg::A_CNT_LO, 36'h0_2800_0000);
    w36(asdu_pkg::A_EXT_LO, 36'h1_2345_6789);
    wr(asdu_pkg::A_FLAGS, 32'h0000_0005, rsp);
    val <= 36'h0_0000_00FF;
    go(cw(asdu_pkg::OP_TALLY, asdu_pkg::FR_F1, 4'hF, 1'b0));
    c36("tally acc", asdu_pkg::A_ACC_LO, 36'h0_0000_00FF);
    r36(asdu_pkg::A_CNT_LO, v);
    cmp("tally cnt", 36'h00D, 36'(v[35:27]));
    c36("tally ext", asdu_pkg::A_EXT_LO, 36'h1_2345_6789);
    cf("tally ovf", 4'h5);
    // joined ring: 13 left steps from the count left by the tally
    go(cw(asdu_pkg::OP_ROT_J, asdu_pkg::FR_F1, 4'hF, 1'b1));
    c36("rotj acc", asdu_pkg::A_ACC_LO, 36'h0_001F_E246);
    c36("rotj ext", asdu_pkg::A_EXT_LO, 36'h8_ACF1_2000);
  endtask : t_tally
  // two subwords, only the upper quarters active on the pins
  task automatic t_frac;
    w36(asdu_pkg::A_ACC_LO, 36'h8_0004_0003);
    val <= 36'h0_0800_0200;
    act <= 4'hC;
    go(cw(asdu_pkg::OP_ROT_P, asdu_pkg::FR_F2, 4'h0, 1'b0));
    c36("frac acc", asdu_pkg::A_ACC_LO, 36'h0_000C_0003);
    act <= 4'hF;
  endtask : t_frac
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_rot();
    t_scl();
    t_nrm();
    t_tally();
    t_frac();
    final_report();
  end
endmodule : tb
